// File: rtl/fhp_cfg.svh
/*
 * Constants for the flash protection and RAM overlay block: register word
 * indices, field positions, reset values and the address map.
 * Assumes inclusion by bare name from the block's package and module.
 */
`ifndef FHP_CFG_SVH
`define FHP_CFG_SVH

// Register word indices on the bus (byte address = index * 4)
`define FHP_IDX_FLASH_CTRL  3'h0
`define FHP_IDX_EBS_FIRST   3'h1
`define FHP_IDX_EBS_SECOND  3'h2
`define FHP_IDX_WAIT_STATE  3'h3
`define FHP_IDX_STATUS      3'h4

// Flash control register field positions
`define FHP_FC_PROG         0
`define FHP_FC_ERASE        1
`define FHP_FC_PV           2
`define FHP_FC_EV           3

// Wait-state control overlay field
`define FHP_WS_OVL_HI       7
`define FHP_WS_OVL_LO       6

// Reset values
`define FHP_FC_RST          8'h00
`define FHP_EBS1_RST        8'hF0
`define FHP_EBS2_RST        8'h00
`define FHP_EBS1_RSVD       8'hF0
`define FHP_WS_RST          8'h08
`define FHP_WS_BOOT_OVL     2'h3

// Overlay selector codes
`define FHP_OVL_NONE        2'h0
`define FHP_OVL_SMALL       2'h1
`define FHP_OVL_WIDE        2'h2
`define FHP_OVL_VECT        2'h3

// Flash windows that can be overlaid, and their RAM sources
`define FHP_FL_VECT_LO      16'h0000
`define FHP_FL_VECT_HI      16'h007F
`define FHP_FL_SMALL_LO     16'h0080
`define FHP_FL_SMALL_HI     16'h00FF
`define FHP_FL_WIDE_HI      16'h017F
`define FHP_RAM_VECT_BASE   16'hFC00
`define FHP_RAM_SMALL_BASE  16'hFC80

// Whole flash array and on-chip RAM spans
`define FHP_FLASH_LO        16'h0000
`define FHP_FLASH_HI        16'h7FFF
`define FHP_RAM_LO          16'hFB80
`define FHP_RAM_HI          16'hFF7F

`endif

// File: rtl/fhp_pkg.sv
/*
 * Types shared by the flash protection and RAM overlay block.
 * Assumes fhp_cfg.svh is on the include path.
 */
`default_nettype none
`include "fhp_cfg.svh"

package fhp_pkg;

	// Protection state, Gray coded along open -> active -> locked
	typedef enum logic [1:0] {
		FHP_OPEN   = 2'h0,
		FHP_ACTIVE = 2'h1,
		FHP_LOCKED = 2'h3
	} fhp_state_t;

	// CPU access to be steered to RAM or flash
	typedef struct packed {
		logic        req;
		logic        vect;
		logic [15:0] addr;
	} fhp_cpu_req_t;

	// Steered access handed on to the memories
	typedef struct packed {
		logic        ram_sel;
		logic        flash_sel;
		logic        data_bad;
		logic [15:0] addr;
	} fhp_mem_sel_t;

	// Result of the overlay lookup
	typedef struct packed {
		logic        hit;
		logic [15:0] addr;
	} fhp_map_t;

	// Status word seen by software
	typedef struct packed {
		logic       erase_run;
		logic       prog_run;
		logic       hw_protect;
		logic       emu_protect;
		logic       cells_bad;
		logic       int_locked;
		logic       vpp_ok;
	} fhp_status_t;

endpackage
`default_nettype wire

// File: rtl/fhp_top.sv
/*
 * Flash hardware protection and RAM overlay remapper with a classic
 * Wishbone register slave. Assumes a CPU that presents one access request
 * per cycle, a flash array that honours the per-block enables, and a
 * single 20 MHz clock with a synchronous active high reset.
 */
// Decided for this implementation: the Wishbone slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "fhp_cfg.svh"

// How it works
// - Without 12 V on the voltage pin, flash registers clear; program/erase/verify off.
// - Any reset, watchdog reset or standby entry clears the flash registers.
// - Interrupt during program or erase aborts it; register contents are kept.
// - Interrupt lock blocks program and erase until the next reset only.
// - Under hardware protection every block is erase-disabled together.
// - Cells count as indeterminate after an interrupt abort.
// - Flash reads are flagged wrong while program or erase bit is set.
// - Interrupt mask bit set lets only the non-maskable interrupt through.
// - Both overlay bits put RAM FC00-FC7F over flash vectors 0000-007F.
// - Overlay bits select none, small, wide or vector window overlay.
// - Overlaid RAM answers both at flash and original RAM addresses.
// - Wait-state register resets on reset and hardware standby only.
// - In boot mode only the non-maskable interrupt is taken, overlay bits set.
// - Exactly one overlay bit set blocks program and erase of all blocks.
// - Block select registers enable blocks; F0 and 00 protect every block.
module fhp_top #(
	parameter int NUM_BLK_FIRST  = 4,
	parameter int NUM_BLK_SECOND = 8
) (
	input  wire logic                 clk_i,
	input  wire logic                 rst_i,
	// Wishbone classic slave
	input  wire logic                 cyc_i,
	input  wire logic                 stb_i,
	input  wire logic                 we_i,
	input  wire logic [4:2]           adr_i,
	input  wire logic [31:0]          dat_i,
	input  wire logic [3:0]           sel_i,
	output logic                      ack_o,
	output logic [31:0]               dat_o,
	// Chip level conditions
	input  wire logic                 prog_voltage_pin_i,
	input  wire logic                 wdt_reset_i,
	input  wire logic                 hw_standby_i,
	input  wire logic                 sw_standby_i,
	input  wire logic                 boot_mode_i,
	// Interrupt sources and mask
	input  wire logic                 irq_i,
	input  wire logic                 nmi_i,
	input  wire logic                 imask_i,
	// CPU access
	input  wire fhp_pkg::fhp_cpu_req_t cpu_req_i,
	output fhp_pkg::fhp_mem_sel_t     mem_sel_o,
	// Flash array controls
	output logic                      prog_en_o,
	output logic                      erase_en_o,
	output logic                      pv_en_o,
	output logic                      ev_en_o,
	output logic [NUM_BLK_FIRST+NUM_BLK_SECOND-1:0] blk_en_o,
	output logic                      abort_o,
	output logic                      int_take_o
);
	import fhp_pkg::*;

	localparam int NBLK = NUM_BLK_FIRST + NUM_BLK_SECOND;

	// Upper nibble of the first select register is reserved, so four at most
	if (NUM_BLK_FIRST < 1 || NUM_BLK_FIRST > 4 ||
	    NUM_BLK_SECOND < 1 || NUM_BLK_SECOND > 8) begin : g_chk
		$error("fhp_top: block count out of range");
	end

	// Overlay lookup, used for the CPU access path only
	function automatic fhp_map_t remap(input logic [1:0] mode,
	                                   input logic [15:0] a);
		fhp_map_t m;
		m.hit  = 1'b0;
		m.addr = a;
		case (mode)
			`FHP_OVL_SMALL: begin
				if (a >= `FHP_FL_SMALL_LO && a <= `FHP_FL_SMALL_HI) begin
					m.hit  = 1'b1;
					m.addr = `FHP_RAM_SMALL_BASE + (a - `FHP_FL_SMALL_LO);
				end
			end
			`FHP_OVL_WIDE: begin
				if (a >= `FHP_FL_SMALL_LO && a <= `FHP_FL_WIDE_HI) begin
					m.hit  = 1'b1;
					m.addr = `FHP_RAM_SMALL_BASE + (a - `FHP_FL_SMALL_LO);
				end
			end
			`FHP_OVL_VECT: begin
				if (a <= `FHP_FL_VECT_HI) begin
					m.hit  = 1'b1;
					m.addr = `FHP_RAM_VECT_BASE + (a - `FHP_FL_VECT_LO);
				end
			end
			default: begin
				m.hit = 1'b0;
			end
		endcase
		return m;
	endfunction

	// Registers
	logic [7:0]  flash_control_reg;
	logic [7:0]  erase_block_sel_first;
	logic [7:0]  erase_block_sel_second;
	logic [7:0]  wait_state_control;
	fhp_state_t  state;
	logic        cells_bad;
	logic        ack;
	logic        sw_standby_d;

	// Decoded views
	logic        clear_flash;
	logic        vpp_ok;
	logic        emu_protect;
	logic        int_event;
	logic        run_req;
	logic        wr_strobe;
	logic [1:0]  ovl_mode;
	logic        overlay_hi;
	logic        overlay_lo;
	fhp_map_t    map;
	fhp_status_t status;

	assign vpp_ok      = prog_voltage_pin_i;
	assign overlay_hi  = wait_state_control[`FHP_WS_OVL_HI];
	assign overlay_lo  = wait_state_control[`FHP_WS_OVL_LO];
	assign ovl_mode    = {overlay_hi, overlay_lo};
	assign emu_protect = overlay_hi ^ overlay_lo;
	// Write lands on the edge where the master sees ack
	assign wr_strobe   = cyc_i && stb_i && we_i && ack && sel_i[0];

	// reset standby
	// Software standby entry taken on the rising edge of the request; hardware standby clears while high
	assign clear_flash = !vpp_ok || wdt_reset_i || hw_standby_i ||
	                     (sw_standby_i && !sw_standby_d);

	assign int_event = nmi_i || (irq_i && !imask_i && !boot_mode_i);

	// Program or erase asked for by software
	assign run_req = flash_control_reg[`FHP_FC_PROG] ||
	                 flash_control_reg[`FHP_FC_ERASE];

	// Standby edge detector
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sw_standby_d <= 1'b0;
		end else begin
			sw_standby_d <= sw_standby_i;
		end
	end

	// Bus answer: one wait cycle, ack drops after one cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack <= 1'b0;
		end else begin
			ack <= cyc_i && stb_i && !ack;
		end
	end

	// Read data, registered with the ack; unmapped words read zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_o <= 32'h0000_0000;
		end else if (cyc_i && stb_i && !ack) begin
			case (adr_i)
				`FHP_IDX_FLASH_CTRL: dat_o <= {24'h00_0000, flash_control_reg};
				`FHP_IDX_EBS_FIRST:  dat_o <= {24'h00_0000, erase_block_sel_first};
				`FHP_IDX_EBS_SECOND: dat_o <= {24'h00_0000, erase_block_sel_second};
				`FHP_IDX_WAIT_STATE: dat_o <= {24'h00_0000, wait_state_control};
				`FHP_IDX_STATUS:     dat_o <= {25'h000_0000, status};
				default:             dat_o <= 32'h0000_0000;
			endcase
		end
	end

	// Flash control register
	always_ff @(posedge clk_i) begin
		if (rst_i || clear_flash) begin
			flash_control_reg <= `FHP_FC_RST;
		end else if (wr_strobe && adr_i == `FHP_IDX_FLASH_CTRL) begin
			flash_control_reg <= dat_i[7:0];
		end
	end

	// block select registers; reserved upper bits of the first read one
	always_ff @(posedge clk_i) begin
		if (rst_i || clear_flash) begin
			erase_block_sel_first  <= `FHP_EBS1_RST;
			erase_block_sel_second <= `FHP_EBS2_RST;
		end else if (wr_strobe) begin
			if (adr_i == `FHP_IDX_EBS_FIRST) begin
				erase_block_sel_first <= dat_i[7:0] | `FHP_EBS1_RSVD;
			end
			if (adr_i == `FHP_IDX_EBS_SECOND) begin
				erase_block_sel_second <= dat_i[7:0];
			end
		end
	end

	// wait-state reset
	// Survives software standby; boot mode leaves both overlay bits set
	always_ff @(posedge clk_i) begin
		if (rst_i || hw_standby_i) begin
			wait_state_control <= `FHP_WS_RST;
			if (boot_mode_i) begin
				wait_state_control[`FHP_WS_OVL_HI:`FHP_WS_OVL_LO] <=
					`FHP_WS_BOOT_OVL;
			end
		end else if (wr_strobe && adr_i == `FHP_IDX_WAIT_STATE) begin
			wait_state_control <= dat_i[7:0];
		end
	end

	// Protection state; only a reset leaves the locked state
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= FHP_OPEN;
		end else begin
			case (state)
				FHP_OPEN: begin
					if (run_req && vpp_ok && !clear_flash) begin
						state <= FHP_ACTIVE;
					end
				end
				FHP_ACTIVE: begin
					if (int_event) begin
						state <= FHP_LOCKED;
					end else if (!run_req || clear_flash) begin
						state <= FHP_OPEN;
					end
				end
				FHP_LOCKED: state <= FHP_LOCKED;
				default:    state <= FHP_OPEN;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cells_bad <= 1'b0;
		end else if (state == FHP_ACTIVE && int_event) begin
			cells_bad <= 1'b1;
		end
	end

	// Abort pulse and interrupt acceptance
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			abort_o    <= 1'b0;
			int_take_o <= 1'b0;
		end else begin
			abort_o    <= state == FHP_ACTIVE && int_event;
			int_take_o <= int_event;
		end
	end

	// Program, erase and verify enables toward the array
	always_ff @(posedge clk_i) begin
		if (rst_i || clear_flash) begin
			prog_en_o  <= 1'b0;
			erase_en_o <= 1'b0;
			pv_en_o    <= 1'b0;
			ev_en_o    <= 1'b0;
			blk_en_o   <= {NBLK{1'b0}};
		end else begin
			prog_en_o  <= flash_control_reg[`FHP_FC_PROG] &&
			              state != FHP_LOCKED && !int_event && !emu_protect;
			erase_en_o <= flash_control_reg[`FHP_FC_ERASE] &&
			              state != FHP_LOCKED && !int_event && !emu_protect;
			// Verify stays usable after an interrupt abort
			pv_en_o    <= flash_control_reg[`FHP_FC_PV];
			ev_en_o    <= flash_control_reg[`FHP_FC_EV];
			if (state == FHP_LOCKED || int_event || emu_protect) begin
				blk_en_o <= '0;
			end else begin
				blk_en_o <= {erase_block_sel_second[NUM_BLK_SECOND-1:0],
				             erase_block_sel_first[NUM_BLK_FIRST-1:0]};
			end
		end
	end

	// Status word
	always_comb begin
		status.vpp_ok      = vpp_ok;
		status.int_locked  = state == FHP_LOCKED;
		status.cells_bad   = cells_bad;
		status.emu_protect = emu_protect;
		status.hw_protect  = !vpp_ok || state == FHP_LOCKED;
		status.prog_run    = prog_en_o;
		status.erase_run   = erase_en_o;
	end

	assign map = remap(ovl_mode, cpu_req_i.addr);

	// CPU access steering, one cycle behind the request
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mem_sel_o <= '0;
		end else begin
			mem_sel_o.addr      <= map.addr;
			mem_sel_o.ram_sel   <= cpu_req_i.req && (map.hit ||
				(cpu_req_i.addr >= `FHP_RAM_LO &&
				 cpu_req_i.addr <= `FHP_RAM_HI));
			mem_sel_o.flash_sel <= cpu_req_i.req && !map.hit &&
				cpu_req_i.addr <= `FHP_FLASH_HI;
			mem_sel_o.data_bad  <= cpu_req_i.req && !map.hit &&
				cpu_req_i.addr <= `FHP_FLASH_HI && run_req;
		end
	end

	assign ack_o = ack;

endmodule
`default_nettype wire

// File: verification/fhp_top_props.sv
/* Assertions on the ports of the flash protection and overlay block.
   Assumes the bind at the foot of this file and one 20 MHz clock. */
`timescale 1ns/100ps
`default_nettype none
`include "fhp_cfg.svh"
module fhp_top_props #(
	parameter int NUM_BLK_FIRST  = 4,
	parameter int NUM_BLK_SECOND = 8
) (
	input wire logic			clk_i,
	input wire logic			rst_i,
	input wire logic			cyc_i,
	input wire logic			stb_i,
	input wire logic			ack_o,
	input wire logic			prog_voltage_pin_i,
	input wire logic			wdt_reset_i,
	input wire logic			hw_standby_i,
	input wire logic			sw_standby_i,
	input wire logic			boot_mode_i,
	input wire logic			irq_i,
	input wire logic			nmi_i,
	input wire logic			imask_i,
	input wire fhp_pkg::fhp_cpu_req_t	cpu_req_i,
	input wire fhp_pkg::fhp_mem_sel_t	mem_sel_o,
	input wire logic			prog_en_o,
	input wire logic			erase_en_o,
	input wire logic			pv_en_o,
	input wire logic			ev_en_o,
	input wire logic [NUM_BLK_FIRST+NUM_BLK_SECOND-1:0] blk_en_o,
	input wire logic			abort_o,
	input wire logic			int_take_o
);
	import fhp_pkg::*;

	// Everything in one domain, muted during reset
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	AST_ACK_ONE: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
		else $error("bus answer not a single cycle");
	AST_ACK_CAUSE: assert property (ack_o |-> $past(cyc_i && stb_i))
		else $error("bus answer without request");
	AST_VPP_OFF: assert property (
		!prog_voltage_pin_i |=> !(prog_en_o | erase_en_o | pv_en_o | ev_en_o)
		&& blk_en_o == '0) else $error("enables up without voltage");
	AST_WDT_CLR: assert property (
		wdt_reset_i |=> !(prog_en_o | erase_en_o | pv_en_o | ev_en_o)
		&& blk_en_o == '0) else $error("watchdog reset kept enables");
	AST_HWS_CLR: assert property (
		hw_standby_i |=> !(prog_en_o | erase_en_o) && blk_en_o == '0)
		else $error("hardware standby kept enables");
	AST_SWS_CLR: assert property (
		$rose(sw_standby_i) |-> ##[1:2] !(prog_en_o | erase_en_o))
		else $error("software standby kept enables");
	AST_ABORT_OFF: assert property (abort_o |-> !prog_en_o && !erase_en_o)
		else $error("abort with program or erase on");
	AST_ABORT_CAUSE: assert property (abort_o |-> $past(irq_i || nmi_i))
		else $error("abort without interrupt");
	AST_LOCK_HOLD: assert property (
		abort_o |=> (!prog_en_o && !erase_en_o) [*8])
		else $error("lock released early");
	AST_MASKED: assert property (imask_i && !nmi_i |=> !int_take_o)
		else $error("masked interrupt taken");
	AST_NMI_TAKE: assert property (nmi_i |=> int_take_o)
		else $error("non-maskable interrupt dropped");
	AST_BOOT_MASK: assert property (boot_mode_i && !nmi_i |=> !int_take_o)
		else $error("interrupt taken in boot mode");
	AST_RAM_HOME: assert property (
		cpu_req_i.req && cpu_req_i.addr >= `FHP_RAM_LO
		&& cpu_req_i.addr <= `FHP_RAM_HI |=> mem_sel_o.ram_sel
		&& mem_sel_o.addr == $past(cpu_req_i.addr))
		else $error("RAM lost at its own address");
endmodule

bind fhp_top fhp_top_props #(
	.NUM_BLK_FIRST (NUM_BLK_FIRST),
	.NUM_BLK_SECOND(NUM_BLK_SECOND)
) u_props (.clk_i, .rst_i, .cyc_i, .stb_i, .ack_o, .prog_voltage_pin_i,
	.wdt_reset_i, .hw_standby_i, .sw_standby_i, .boot_mode_i, .irq_i,
	.nmi_i, .imask_i, .cpu_req_i, .mem_sel_o, .prog_en_o, .erase_en_o,
	.pv_en_o, .ev_en_o, .blk_en_o, .abort_o, .int_take_o);
`default_nettype wire

// File: verification/fhp_cpu_model.sv
/* Behavioural CPU core issuing single fetch requests.
   Assumes the block samples a request at the next rising edge. */
`timescale 1ns/100ps
`default_nettype none
module fhp_cpu_model (
	input  wire logic		clk_i,
	output var fhp_pkg::fhp_cpu_req_t	cpu_req_o
);
	import fhp_pkg::*;

	// Quiet bus at start
	initial cpu_req_o = '0;

	// One request cycle, then the address inverts so nothing stale shows
	task automatic fetch(input logic [15:0] a);
		@(posedge clk_i);
		cpu_req_o <= '{1'b1, a[15:7] == 9'h000, a};
		@(posedge clk_i);
		cpu_req_o <= '{1'b0, 1'b0, ~a};
	endtask
endmodule
`default_nettype wire

// File: verification/tb_top.sv
/* Self-checking bench for the flash protection and overlay block.
   Assumes the design package, the checker bind and the CPU model. */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import fhp_pkg::*;

	logic		clk_i, rst_i, cyc_i, stb_i, we_i, ack_o;
	logic		prog_voltage_pin_i, wdt_reset_i, hw_standby_i;
	logic		sw_standby_i, boot_mode_i, irq_i, nmi_i, imask_i;
	logic		prog_en_o, erase_en_o, pv_en_o, ev_en_o;
	logic		abort_o, int_take_o;
	logic [4:2]	adr_i;
	logic [31:0]	dat_i, dat_o;
	logic [3:0]	sel_i;
	logic [11:0]	blk_en_o;
	logic [7:0]	rd;
	logic [3:0]	bsel = 4'hF;
	fhp_cpu_req_t	cpu_req_i;
	fhp_mem_sel_t	mem_sel_o;
	int		errors = 0;
	int		tests_run = 0;

	// Selector, fetch address, RAM hit, steered address
	localparam logic [34:0] OVT [6] = '{
		{2'h0, 16'h0006, 1'b0, 16'h0006},
		{2'h1, 16'h0090, 1'b1, 16'hFC90},
		{2'h1, 16'h0006, 1'b0, 16'h0006},
		{2'h2, 16'h0170, 1'b1, 16'hFD70},
		{2'h3, 16'h0006, 1'b1, 16'hFC06},
		{2'h3, 16'hFC06, 1'b1, 16'hFC06}};
	localparam logic [7:0] RV [4] = '{8'h00, 8'hF0, 8'h00, 8'h08};

	fhp_top dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .dat_i,
		.sel_i, .ack_o, .dat_o, .prog_voltage_pin_i, .wdt_reset_i,
		.hw_standby_i, .sw_standby_i, .boot_mode_i, .irq_i, .nmi_i,
		.imask_i, .cpu_req_i, .mem_sel_o, .prog_en_o, .erase_en_o,
		.pv_en_o, .ev_en_o, .blk_en_o, .abort_o, .int_take_o);

	fhp_cpu_model cpu (.clk_i, .cpu_req_o(cpu_req_i));

	// 50 ns clock
	always #25 clk_i = ~clk_i;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic end_of_test;
		$display("compares %0d, mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Classic cycle held until ack is sampled; idle cycle comes first
	task automatic bus(input logic w, input logic [2:0] a,
			input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= {24'h0, d};
		sel_i <= bsel;
		// Waits as long as it takes; the hang guard ends a stuck run
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1);
		// Answer due on the second edge after the request
		chk(n, 2);
		rd = dat_o[7:0];
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
	endtask

	task automatic rchk(input logic [2:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		chk(rd, e);
	endtask

	task automatic step;
		@(posedge clk_i);
		#1;
	endtask

	// One-cycle strobe: imask, wdt, hw stby, sw stby, irq, nmi
	task automatic pulse(input logic [5:0] p);
		@(posedge clk_i);
		{imask_i, wdt_reset_i, hw_standby_i, sw_standby_i, irq_i, nmi_i} <= p;
		@(posedge clk_i);
		{imask_i, wdt_reset_i, hw_standby_i, sw_standby_i, irq_i, nmi_i} <= '0;
		#1;
	endtask

	task automatic fchk(input logic [15:0] a, input logic r,
			input logic [15:0] x);
		cpu.fetch(a);
		#1;
		chk({mem_sel_o.ram_sel, mem_sel_o.flash_sel, mem_sel_o.addr},
			{r, ~r, x});
	endtask

	task automatic rst(input int n);
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (n) @(posedge clk_i);
		rst_i <= 1'b0;
	endtask

	task automatic sc_regs;
		for (int i = 0; i < 4; i++)
			rchk(3'(i), RV[i]);
		rchk(3'h5, 8'h00);
		bus(1'b1, 3'h3, 8'h5A);
		rchk(3'h3, 8'h5A);
		// Write without lane 0 must be ignored
		bsel = 4'hE;
		bus(1'b1, 3'h3, 8'h77);
		bsel = 4'hF;
		rchk(3'h3, 8'h5A);
		bus(1'b1, 3'h3, 8'h08);
	endtask

	task automatic sc_vpp;
		bus(1'b1, 3'h1, 8'hFF);
		bus(1'b1, 3'h2, 8'hFF);
		bus(1'b1, 3'h0, 8'h03);
		step;
		chk({prog_en_o, erase_en_o, blk_en_o}, 14'h3FFF);
		@(posedge clk_i);
		prog_voltage_pin_i <= 1'b0;
		step;
		step;
		chk({prog_en_o, erase_en_o, pv_en_o, ev_en_o, blk_en_o}, 0);
		bus(1'b1, 3'h0, 8'h0C);
		rchk(3'h0, 8'h00);
		@(posedge clk_i);
		prog_voltage_pin_i <= 1'b1;
		bus(1'b1, 3'h0, 8'h0C);
		step;
		chk({pv_en_o, ev_en_o}, 2'b11);
		pulse(6'b010000); // watchdog fires while enabled
		step;
		chk({pv_en_o, ev_en_o, blk_en_o}, 0);
		rchk(3'h1, 8'hF0);
		bus(1'b1, 3'h3, 8'h2C);
		bus(1'b1, 3'h0, 8'h0C);
		pulse(6'b000100);
		rchk(3'h0, 8'h00);
		rchk(3'h3, 8'h2C);
		pulse(6'b001000);
		rchk(3'h3, 8'h08);
	endtask

	task automatic sc_emu;
		logic [3:0] e;
		for (int c = 0; c < 4; c++) begin
			e = (c == 1 || c == 2) ? 4'h3 : 4'hF;
			bus(1'b1, 3'h3, {2'(c), 6'h08});
			bus(1'b1, 3'h0, 8'h0F);
			step;
			chk({prog_en_o, erase_en_o, pv_en_o, ev_en_o}, e);
			bus(1'b1, 3'h0, 8'h00);
		end
	endtask

	task automatic sc_ovl;
		// vector word at FC06 is fetched from RAM once both bits rise
		for (int i = 0; i < 6; i++) begin
			bus(1'b1, 3'h3, {OVT[i][34:33], 6'h08});
			fchk(OVT[i][32:17], OVT[i][16], OVT[i][15:0]);
		end
		bus(1'b1, 3'h3, 8'h08);
	endtask

	task automatic sc_irq;
		bus(1'b1, 3'h0, 8'h01);
		fchk(16'h0100, 1'b0, 16'h0100);
		chk(mem_sel_o.data_bad, 1'b1);
		pulse(6'b100010);
		chk({int_take_o, abort_o, prog_en_o}, 3'b001);
		pulse(6'b000010);
		chk({int_take_o, abort_o}, 2'b11);
		step;
		chk({abort_o, prog_en_o}, 2'b00);
		rchk(3'h0, 8'h01);
		bus(1'b1, 3'h0, 8'h05);
		step;
		chk({prog_en_o, pv_en_o}, 2'b01);
		bus(1'b0, 3'h4, 8'h00);
		chk(rd[2:1], 2'b11);
		// Ten cycles of reset, as the outside world must give
		rst(10);
		bus(1'b1, 3'h0, 8'h01);
		step;
		chk(prog_en_o, 1'b1);
		bus(1'b1, 3'h0, 8'h00);
	endtask

	task automatic sc_boot;
		@(posedge clk_i);
		boot_mode_i <= 1'b1;
		rst(10);
		rchk(3'h3, 8'hC8);
		pulse(6'b000010);
		chk(int_take_o, 1'b0);
		pulse(6'b000001);
		chk(int_take_o, 1'b1);
		fchk(16'h0006, 1'b1, 16'hFC06);
		// Boot handler area stays reachable at its home address
		fchk(16'hFB80, 1'b1, 16'hFB80);
		// Loaded program without interrupts drops the overlay
		bus(1'b1, 3'h3, 8'h08);
		fchk(16'h0006, 1'b0, 16'h0006);
		@(posedge clk_i);
		boot_mode_i <= 1'b0;
	endtask

	// Main sequence
	initial begin
		clk_i = 1'b0;
		rst_i = 1'b1;
		{cyc_i, stb_i, we_i, adr_i, dat_i} = '0;
		{imask_i, wdt_reset_i, hw_standby_i, sw_standby_i, irq_i, nmi_i} = '0;
		boot_mode_i = 1'b0;
		sel_i = 4'hF;
		prog_voltage_pin_i = 1'b1;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		sc_regs;
		sc_vpp;
		sc_emu;
		sc_ovl;
		sc_irq;
		sc_boot;
		end_of_test;
	end

	// Hang guard, far beyond the few hundred cycles needed
	initial begin
		#200000;
		errors++;
		end_of_test;
	end
endmodule
`default_nettype wire
